//--- tb/host_model.sv
// host side: serial watchdog command pair and free-running pwm clock
// assumes the bench pulses go for one cycle, at most once per pair
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock and control
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic go,
  // serial command and pwm clock
  output logic      cmd_valid,
  output logic      watchdog_toggle_bit,
  output logic      pwm_clock_pin
);
  logic [2:0] step_q;
  initial pwm_clock_pin = 1'b0;
  always #62.5 pwm_clock_pin = ~pwm_clock_pin;
  // toggle bit first 0, then 1, four cycles apart
  always_ff @(posedge clk) begin
    cmd_valid           <= 1'b0;
    watchdog_toggle_bit <= ~watchdog_toggle_bit;
    if (srst) begin
      step_q              <= 3'h0;
      watchdog_toggle_bit <= 1'b1;
    end else if (go) begin
      step_q              <= 3'h1;
      cmd_valid           <= 1'b1;
      watchdog_toggle_bit <= 1'b0;
    end else if (step_q != 3'h0) begin
      step_q <= step_q + 3'h1;
      if (step_q == 3'h4) begin
        cmd_valid           <= 1'b1;
        watchdog_toggle_bit <= 1'b1;
        step_q              <= 3'h0;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/switch_operating_mode_control_test.sv
// bench for the operating-mode controller
// assumes the design package and host_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module switch_operating_mode_control_test;
  import mode_ctl_pkg::*;
  logic clk = 1'b0, srst = 1'b1, go = 1'b0, psup = 1'b1, lsup = 1'b1, pin = 1'b0, fbk = 1'b0;
  logic [3:0] wdet = 4'h0, dir = 4'h0, sel = 4'h0;
  logic link_fault = 1'b0, stuck = 1'b0, cfg_wr = 1'b0, cmd_v, tog, pclk, rvalid, pmax, sense, ext;
  logic [15:0] rdata;
  logic [47:0] flt = 48'h81;
  logic [4:0] ocw, pout;
  logic [5:0] drv;
  cfg_type cfg = '0;
  prot_type prot = '0;
  mode_type mode;
  int fail_count = 0, n_compared = 0, cycles = 0;
  always #5 clk = ~clk;
  host_model host (.clk(clk), .srst(srst), .go(go), .cmd_valid(cmd_v), .watchdog_toggle_bit(tog),
    .pwm_clock_pin(pclk));
  switch_operating_mode_control #(.RECOVER_WINDOW(20)) dut (.clk(clk), .srst(srst), .clk_en(1'b1),
    .power_supply_ok(psup), .logic_supply_ok(lsup), .active_low_wake_pin(pin),
    .per_input_wake_detect(wdet), .fallback_request(fbk), .direct_control_inputs(dir),
    .pwm_clock_pin(pclk), .serial_link_fault(link_fault), .serial_link_stuck(stuck),
    .cfg_write(cfg_wr), .cfg_wdata(cfg), .cmd_valid(cmd_v), .watchdog_toggle_bit(tog),
    .readout_select_bits(sel), .readout_data(rdata), .readout_valid(rvalid), .prot(prot),
    .faults(flt), .oc_window_start(ocw), .overcurrent_profile_max(pmax),
    .current_sense_feedback(sense), .channel_drive(drv), .power_outputs(pout),
    .external_switch_control_output(ext), .mode(mode));
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // wait n edges, then sample once their updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_mode(input mode_type m);
    for (int k = 0; k < 20 && mode !== m; k++) cyc(1);
    chk("mode", 16'(m), 16'(mode));
  endtask
  task automatic pulse_cfg(input cfg_type c);
    @(posedge clk) begin cfg <= c; cfg_wr <= 1'b1; end
    @(posedge clk) cfg_wr <= 1'b0;
    cyc(3);
  endtask
  task automatic t_reset_sleep();
    cyc(4);
    chk("mode after reset", 16'(MODE_OFF), 16'(mode));
    chk("drive in reset", 16'h0000, 16'(drv));
    @(posedge clk) srst <= 1'b0;
    wait_mode(MODE_SLEEP);
    chk("drive in sleep", 16'h0000, 16'(drv));
    chk("window in sleep", 16'h0000, 16'(ocw));
  endtask
  task automatic t_wake_sources();
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) begin
        if (i < 4) wdet[i] <= 1'b1;
        else pin <= 1'b1;
      end
      wait_mode(MODE_NORMAL);
      chk("sense in normal", 16'h0001, 16'(sense));
      @(posedge clk) begin wdet <= 4'h0; pin <= 1'b0; end
      wait_mode(MODE_SLEEP);
    end
  endtask
  task automatic t_normal();
    cfg_type c;
    c = '0;
    c.direct_sel = 4'h1;
    c.duty = {6{8'hff}};
    @(posedge clk) pin <= 1'b1;
    wait_mode(MODE_NORMAL);
    pulse_cfg(c);
    chk("drive direct low", 16'h0000, 16'(drv));
    @(posedge clk) dir <= 4'h1;
    for (int k = 0; k < 10 && drv[0] !== 1'b1; k++) cyc(1);
    chk("drive ch1 direct", 16'h0001, 16'(drv));
    chk("window on rise", 16'h0001, 16'(ocw));
    chk("profile normal", 16'h0000, 16'(pmax));
    chk("readout valid", 16'h0001, 16'(rvalid));
    chk("readout normal", 16'h4081, rdata);
    c.direct_sel = 4'h0;
    c.on = 6'h30;
    c.duty[5] = 8'h00;
    pulse_cfg(c);
    chk("drive on bits duty", 16'h0010, 16'(drv));
    chk("drive ch6 duty zero", 16'h0000, 16'(ext));
    @(posedge clk) lsup <= 1'b0;
    cyc(5);
    chk("readout no supply", 16'h0000, 16'(rvalid));
    @(posedge clk) lsup <= 1'b1;
  endtask
  task automatic t_fail();
    cfg_type c;
    c = '0;
    c.on = 6'h3f;
    c.duty = {6{8'hff}};
    @(posedge clk) begin fbk <= 1'b1; dir <= 4'ha; end
    wait_mode(MODE_FAIL);
    cyc(3);
    chk("fail drive", 16'h000a, 16'(drv));
    chk("fail outputs", 16'h000a, 16'(pout));
    chk("fail ext", 16'h0000, 16'(ext));
    chk("fail profile", 16'h0001, 16'(pmax));
    chk("fail sense", 16'h0000, 16'(sense));
    @(posedge clk) wdet <= 4'h4;
    cyc(3);
    chk("fail window from wake detect", 16'h0004, 16'(ocw));
    @(posedge clk) wdet <= 4'h0;
    pulse_cfg(c);
    chk("fail write ignored", 16'h000a, 16'(drv));
    chk("fail readout", 16'h0001, 16'(rvalid));
    chk("fail readout data", 16'h8081, rdata);
    @(posedge clk) prot.overtemp[1] <= 1'b1;
    @(posedge clk) prot.overtemp[1] <= 1'b0;
    cyc(3);
    chk("latched off", 16'h0008, 16'(drv));
    // overload reloads a 1000-cycle restart wait on channel 4
    @(posedge clk) prot.overload[3] <= 1'b1;
    @(posedge clk) prot.overload[3] <= 1'b0;
    cyc(2);
    chk("restart blocks drive", 16'h0000, 16'(drv));
    cyc(990);
    chk("restart still waiting", 16'h0000, 16'(drv));
    cyc(10);
    chk("restart released", 16'h0008, 16'(drv));
    @(posedge clk) stuck <= 1'b1;
    cyc(3);
    chk("stuck readout", 16'h0000, 16'(rvalid));
  endtask
  task automatic t_recover();
    @(posedge clk) begin fbk <= 1'b0; stuck <= 1'b0; end
    cyc(6);
    chk("fail hold", 16'(MODE_FAIL), 16'(mode));
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    wait_mode(MODE_NORMAL);
    cyc(3);
    chk("settings cleared", 16'h0000, 16'(drv));
    @(posedge clk) link_fault <= 1'b1;
    wait_mode(MODE_FAIL);
    @(posedge clk) link_fault <= 1'b0;
  endtask
  task automatic t_priority();
    @(posedge clk) begin pin <= 1'b0; fbk <= 1'b1; end
    wait_mode(MODE_SLEEP);
    @(posedge clk) begin psup <= 1'b0; lsup <= 1'b0; pin <= 1'b1; end
    wait_mode(MODE_OFF);
    chk("off drive", 16'h0000, 16'(drv));
  endtask
  initial begin
    t_reset_sleep();
    t_wake_sources();
    t_normal();
    t_fail();
    t_recover();
    t_priority();
    give_verdict();
  end
endmodule
`default_nettype wire

//--- verilog/mode_ctl_defines.svh
// constants for the operating-mode controller
// assumes a 100 MHz logic clock
`ifndef MODE_CTL_DEFINES_SVH
`define MODE_CTL_DEFINES_SVH
`define CLK_PERIOD_NS      10
`define RESTART_TIME_NS    10000
`define RESTART_CYCLES     (`RESTART_TIME_NS / `CLK_PERIOD_NS)
`define RECOVER_WINDOW_DEF 4000
`define NUM_CH             6
`define NUM_DIRECT         4
`define NUM_OC_CH          5
`define DUTY_W             8
`define PRESC_W            2
`define TICK_W             11
`define SEL_W              4
`define WORD_W             16
`define CNT_W              16
`endif

//--- verilog/mode_ctl_pkg.sv
// types shared by the operating-mode controller
// assumes mode_ctl_defines.svh is on the include path
`include "mode_ctl_defines.svh"
package mode_ctl_pkg;
  typedef enum logic [3:0] {
    MODE_OFF    = 4'h1,
    MODE_SLEEP  = 4'h2,
    MODE_NORMAL = 4'h4,
    MODE_FAIL   = 4'h8
  } mode_type;

  // serial-programmed channel settings
  typedef struct packed {
    logic [`NUM_CH-1:0]                    on;
    logic [`NUM_DIRECT-1:0]                direct_sel;
    logic [`NUM_CH-1:0][`DUTY_W-1:0]       duty;
    logic [`NUM_CH-1:0][`PRESC_W-1:0]      presc;
  } cfg_type;

  // per-channel fault report
  typedef struct packed {
    logic open_load;
    logic short_supply;
    logic severe_short;
    logic overcurrent;
    logic overtemp;
    logic clock_fail;
    logic undervoltage;
    logic overvoltage;
  } fault_type;

  // protection events per direct channel plus one shared undervoltage, on the logic clock
  typedef struct packed {
    logic [`NUM_DIRECT-1:0] overload;
    logic [`NUM_DIRECT-1:0] overtemp;
    logic [`NUM_DIRECT-1:0] high_oc;
    logic [`NUM_DIRECT-1:0] severe_short;
    logic                   undervoltage;
  } prot_type;
endpackage

//--- verilog/switch_operating_mode_control.sv
// operating-mode controller of a multi-channel high-side switch
// assumes pins arrive asynchronous; config, faults and commands come from same-clock logic
// Summary of operation
// - four modes: power off, sleep, normal, fail; channels controlled independently
// - wake term is OR of four per-input wake detects and wake pin
// - fail term is OR of serial link fault and fallback request input
// - both supplies below reset threshold gives power off, no logic function
// - with wake term low after power-up the device rests in sleep
// - sleep disables all outputs; only the wake term or loss of both supplies leaves sleep
// - normal exactly when a supply is present, wake term is 1, fail term is 0 and the fail hold is clear
// - normal mode drives outputs from serial-configured PWM; status read serially
// - each channel has its own 8-bit duty PWM with prescaler
// - normal: drives 1-4 follow on bit or direct input; 5-6 on bit
// - normal: rising drive of channels 1-5 starts its overcurrent window
// - fail: outputs 1-4 follow their direct control inputs
// - fail: outputs 5 and 6 forced off, PWM unavailable
// - fail: writes ignored; readout still follows select bits if cause permits
// - fail: current-sense feedback disabled
// - fail: maximum overcurrent profile with low threshold forced
// - fail: overload or undervoltage gives auto-restart on outputs 1-4
// - fail: overtemp, high threshold or severe short latch output off until wake
// - fail: drives 1-4 follow direct inputs, windows from wake detects, 5-6 off
// - serial readout only while logic supply present
// - eight fault types reported in the serial readout
// - PWM supports load frequencies up to 400 Hz
// - normal to fail clears serial settings, keeps readout registers
// - fail to normal needs cause removed and toggle 0 then 1 in window
`timescale 1ns/10ps
`default_nettype none
`include "mode_ctl_defines.svh"
module switch_operating_mode_control #(
  parameter int RECOVER_WINDOW = `RECOVER_WINDOW_DEF
) (
  // clock and control
  input  wire logic                                  clk,
  input  wire logic                                  srst,
  input  wire logic                                  clk_en,
  // supply, wake, fallback, direct control and pwm clock pins
  input  wire logic                                  power_supply_ok,
  input  wire logic                                  logic_supply_ok,
  input  wire logic                                  active_low_wake_pin,
  input  wire logic [`NUM_DIRECT-1:0]                per_input_wake_detect,
  input  wire logic                                  fallback_request,
  input  wire logic [`NUM_DIRECT-1:0]                direct_control_inputs,
  input  wire logic                                  pwm_clock_pin,
  // serial side
  input  wire logic                                  serial_link_fault,
  input  wire logic                                  serial_link_stuck,
  input  wire logic                                  cfg_write,
  input  wire mode_ctl_pkg::cfg_type                 cfg_wdata,
  input  wire logic                                  cmd_valid,
  input  wire logic                                  watchdog_toggle_bit,
  input  wire logic [`SEL_W-1:0]                     readout_select_bits,
  output logic [`WORD_W-1:0]                         readout_data,
  output logic                                       readout_valid,
  // protection and diagnosis
  input  wire mode_ctl_pkg::prot_type                prot,
  input  wire mode_ctl_pkg::fault_type [`NUM_CH-1:0] faults,
  output logic [`NUM_OC_CH-1:0]                      oc_window_start,
  output logic                                       overcurrent_profile_max,
  output logic                                       current_sense_feedback,
  // channel outputs
  output logic [`NUM_CH-1:0]                         channel_drive,
  output logic [`NUM_OC_CH-1:0]                      power_outputs,
  output logic                                       external_switch_control_output,
  output mode_ctl_pkg::mode_type                     mode
);
  import mode_ctl_pkg::*;

  localparam int NP = 8 + 2 * `NUM_DIRECT;

  function automatic logic [`DUTY_W-1:0] pwm_phase(input logic [`TICK_W-1:0] t,
                                                   input logic [`PRESC_W-1:0] p);
    logic [`TICK_W-1:0] s;
    s = t >> p;
    return s[`DUTY_W-1:0];
  endfunction

  // pin synchronisers
  logic [NP-1:0] pins, s1_q, s1_d, s2_q, s2_d;
  always_comb begin
    pins = {power_supply_ok, logic_supply_ok, active_low_wake_pin, fallback_request,
            pwm_clock_pin, 3'h0, per_input_wake_detect, direct_control_inputs};
    s1_d = pins;
    s2_d = s1_q;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (clk_en) begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  logic                   pwr_s, vcc_s, pin_s, limp_s, pclk_s;
  logic [`NUM_DIRECT-1:0] wdet_s, idin;
  logic                   wake_term, fail_term;
  always_comb begin
    {pwr_s, vcc_s, pin_s, limp_s, pclk_s} = s2_q[NP-1:NP-5];
    wdet_s    = s2_q[2*`NUM_DIRECT-1:`NUM_DIRECT];
    idin      = s2_q[`NUM_DIRECT-1:0];
    wake_term = (|wdet_s) | pin_s;
    fail_term = serial_link_fault | limp_s;
  end

  // mode, fail hold and recovery window
  mode_type            mode_q, mode_d;
  logic                hold_q, hold_d, arm_q, arm_d, wake_q, wake_d;
  logic [`CNT_W-1:0]   rec_q, rec_d;
  logic                fail_eff, new_wake;
  always_comb begin
    new_wake = wake_term & ~wake_q;
    fail_eff = fail_term | hold_q;
    wake_d   = wake_term;
    hold_d   = hold_q;
    arm_d    = arm_q;
    rec_d    = rec_q;
    if (mode_q != MODE_FAIL || fail_term) begin
      arm_d = 1'b0;
      rec_d = '0;
    end else if (cmd_valid && !watchdog_toggle_bit) begin
      arm_d = 1'b1;
      rec_d = '0;
    end else if (arm_q && cmd_valid && watchdog_toggle_bit) begin
      arm_d  = 1'b0;
      hold_d = 1'b0;
    end else if (arm_q) begin
      if (rec_q >= (`CNT_W)'(RECOVER_WINDOW - 1)) arm_d = 1'b0;
      rec_d = rec_q + 1'b1;
    end
    if (fail_term && wake_term) hold_d = 1'b1;
    if (!wake_term) hold_d = 1'b0;
    if (!pwr_s && !vcc_s) mode_d = MODE_OFF;
    else if (!wake_term)  mode_d = MODE_SLEEP;
    else if (fail_eff)    mode_d = MODE_FAIL;
    else                  mode_d = MODE_NORMAL;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= MODE_OFF;
      hold_q <= 1'b0;
      arm_q  <= 1'b0;
      rec_q  <= '0;
      wake_q <= 1'b0;
    end else if (clk_en) begin
      mode_q <= mode_d;
      hold_q <= hold_d;
      arm_q  <= arm_d;
      rec_q  <= rec_d;
      wake_q <= wake_d;
    end
  end

  // serial settings: writes ignored outside normal, cleared on entry to fail
  cfg_type cfg_q, cfg_d;
  always_comb begin
    cfg_d = cfg_q;
    if (mode_d != MODE_NORMAL && mode_d != MODE_FAIL) cfg_d = '0;
    else if (mode_q == MODE_NORMAL && mode_d == MODE_FAIL) cfg_d = '0;
    else if (cfg_write && mode_q == MODE_NORMAL && mode_d == MODE_NORMAL) cfg_d = cfg_wdata;
  end
  always_ff @(posedge clk) begin
    if (srst) cfg_q <= '0;
    else if (clk_en) cfg_q <= cfg_d;
  end

  // pwm time base from the sampled external clock
  logic                pclk_q, pclk_d;
  logic [`TICK_W-1:0]  tick_q, tick_d;
  always_comb begin
    pclk_d = pclk_s;
    tick_d = (pclk_s && !pclk_q) ? tick_q + 1'b1 : tick_q;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      pclk_q <= 1'b0;
      tick_q <= '0;
    end else if (clk_en) begin
      pclk_q <= pclk_d;
      tick_q <= tick_d;
    end
  end

  // fail-mode protection: latch-off and auto-restart
  logic [`NUM_DIRECT-1:0]                latch_q, latch_d;
  logic [`NUM_DIRECT-1:0][`CNT_W-1:0]    rst_q, rst_d;
  always_comb begin
    latch_d = latch_q;
    rst_d   = rst_q;
    for (int i = 0; i < `NUM_DIRECT; i++) begin
      // a fault in the same cycle as a new wake keeps the latch set
      if (mode_q == MODE_FAIL &&
          (prot.overtemp[i] | prot.high_oc[i] | prot.severe_short[i]))
        latch_d[i] = 1'b1;
      else if (new_wake) latch_d[i] = 1'b0;
      if (mode_q == MODE_FAIL && (prot.overload[i] | prot.undervoltage))
        rst_d[i] = (`CNT_W)'(`RESTART_CYCLES);
      else if (rst_q[i] != '0)
        rst_d[i] = rst_q[i] - 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      latch_q <= '0;
      rst_q   <= '0;
    end else if (clk_en) begin
      latch_q <= latch_d;
      rst_q   <= rst_d;
    end
  end

  // channel drive, outputs and window starts
  logic [`NUM_CH-1:0]     drv_q, drv_d;
  logic [`NUM_OC_CH-1:0]  ocw_q, ocw_d;
  logic [`NUM_DIRECT-1:0] wdet_q, wdet_d;
  logic [`NUM_CH-1:0]     pwm;
  always_comb begin
    wdet_d = wdet_s;
    for (int i = 0; i < `NUM_CH; i++)
      pwm[i] = cfg_q.on[i] & (pwm_phase(tick_q, cfg_q.presc[i]) < cfg_q.duty[i]);
    drv_d = '0;
    if (mode_d == MODE_NORMAL && mode_q == MODE_NORMAL) begin
      drv_d = pwm;
      for (int i = 0; i < `NUM_DIRECT; i++)
        if (cfg_q.direct_sel[i]) drv_d[i] = idin[i];
    end else if (mode_d == MODE_FAIL) begin
      for (int i = 0; i < `NUM_DIRECT; i++)
        drv_d[i] = idin[i] & ~latch_d[i] & (rst_d[i] == '0);
    end
    ocw_d = '0;
    if (mode_d == MODE_FAIL)
      ocw_d[`NUM_DIRECT-1:0] = wdet_s & ~wdet_q;
    else
      ocw_d = drv_d[`NUM_OC_CH-1:0] & ~drv_q[`NUM_OC_CH-1:0];
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      drv_q  <= '0;
      ocw_q  <= '0;
      wdet_q <= '0;
    end else if (clk_en) begin
      drv_q  <= drv_d;
      ocw_q  <= ocw_d;
      wdet_q <= wdet_d;
    end
  end

  // serial readout
  logic [`WORD_W-1:0] rd_q, rd_d;
  logic               rv_q, rv_d;
  always_comb begin
    rv_d = vcc_s && (mode_q == MODE_NORMAL || (mode_q == MODE_FAIL && !serial_link_stuck));
    rd_d = '0;
    if (rv_d && readout_select_bits < (`SEL_W)'(`NUM_CH))
      rd_d = {mode_q, 4'h0, faults[readout_select_bits]};
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_q <= '0;
      rv_q <= 1'b0;
    end else if (clk_en) begin
      rd_q <= rd_d;
      rv_q <= rv_d;
    end
  end

  always_comb begin
    mode                           = mode_q;
    channel_drive                  = drv_q;
    power_outputs                  = drv_q[`NUM_OC_CH-1:0];
    external_switch_control_output = drv_q[`NUM_CH-1];
    oc_window_start                = ocw_q;
    overcurrent_profile_max        = (mode_q == MODE_FAIL);
    current_sense_feedback         = (mode_q == MODE_NORMAL);
    readout_data                   = rd_q;
    readout_valid                  = rv_q;
  end

  sequence seq_enter_fail;
    mode_q == MODE_NORMAL ##1 mode_q == MODE_FAIL;
  endsequence

  a_wake_term_or: assert property (@(posedge clk) disable iff (srst)
    clk_en && (pwr_s | vcc_s) && !((|wdet_s) | pin_s) |=> mode_q == MODE_SLEEP) else $error("wake term wrong");
  a_fail_term_or: assert property (@(posedge clk) disable iff (srst)
    clk_en && (pwr_s | vcc_s) && ((|wdet_s) | pin_s) && (serial_link_fault | limp_s) |=> mode_q == MODE_FAIL)
    else $error("fail term wrong");
  a_power_off_mode: assert property (@(posedge clk) disable iff (srst)
    clk_en && !pwr_s && !vcc_s |=> mode_q == MODE_OFF) else $error("not off");
  a_normal_exact: assert property (@(posedge clk) disable iff (srst)
    clk_en && (pwr_s | vcc_s) && wake_term && !fail_term && !hold_q |=> mode_q == MODE_NORMAL)
    else $error("normal missed");
  a_sleep_outputs_off: assert property (@(posedge clk) disable iff (srst)
    mode_q == MODE_SLEEP && $past(mode_q) == MODE_SLEEP |-> drv_q == '0) else $error("drive in sleep");
  a_fail_high_off: assert property (@(posedge clk) disable iff (srst)
    mode_q == MODE_FAIL |-> !external_switch_control_output && !power_outputs[`NUM_OC_CH-1])
    else $error("ch5/6 on in fail");
  a_fail_sense_off: assert property (@(posedge clk) disable iff (srst)
    mode_q == MODE_FAIL |-> !current_sense_feedback && overcurrent_profile_max) else $error("fail outputs");
  a_fail_clear_cfg: assert property (@(posedge clk) disable iff (srst)
    seq_enter_fail |-> cfg_q == '0) else $error("settings kept");
  a_latch_off_hold: assert property (@(posedge clk) disable iff (srst)
    clk_en && mode_q == MODE_FAIL && prot.overtemp[1] |=> !drv_q[1]) else $error("not latched");
  a_readout_supply: assert property (@(posedge clk) disable iff (srst)
    !vcc_s && clk_en |=> !readout_valid && readout_data == '0) else $error("readout w/o supply");
endmodule
`default_nettype wire
